// ---- gpib_aux_pkg.sv ----
/*
 * Command codes, timing counts and decode helpers for the auxiliary
 * command decoder of the IEEE 488 talker/listener interface.
 * Assumes an 8-bit command register written by the host processor.
 */
package gpib_aux_pkg;

    localparam int CMD_WIDTH = 8;

    localparam logic [7:0] CMD_SWRST_CLR = 8'h00;
    localparam logic [7:0] CMD_SWRST_SET = 8'h80;
    localparam logic [7:0] CMD_DAC_INVALID = 8'h01;
    localparam logic [7:0] CMD_DAC_VALID = 8'h81;
    localparam logic [7:0] CMD_RFD_RELEASE = 8'h02;
    localparam logic [7:0] CMD_HDFA_CLR = 8'h03;
    localparam logic [7:0] CMD_HDFA_SET = 8'h83;
    localparam logic [7:0] CMD_HDFE_CLR = 8'h04;
    localparam logic [7:0] CMD_HDFE_SET = 8'h84;
    localparam logic [7:0] CMD_NBA_FALSE = 8'h05;
    localparam logic [7:0] CMD_FGET_CLR = 8'h06;
    localparam logic [7:0] CMD_FGET_SET = 8'h86;
    localparam logic [7:0] CMD_RTL_CLR = 8'h07;
    localparam logic [7:0] CMD_RTL_SET = 8'h87;

    // Least length of the trigger pulse, in clock cycles
    localparam int TRIG_PULSE_CYCLES = 5;

    function automatic logic code_match(logic wr, logic [7:0] data, logic [7:0] code);
        return wr && (data == code);
    endfunction

    function automatic logic code_defined(logic [7:0] d);
        return (d == CMD_SWRST_CLR) || (d == CMD_SWRST_SET) ||
               (d == CMD_DAC_INVALID) || (d == CMD_DAC_VALID) ||
               (d == CMD_RFD_RELEASE) || (d == CMD_HDFA_CLR) ||
               (d == CMD_HDFA_SET) || (d == CMD_HDFE_CLR) ||
               (d == CMD_HDFE_SET) || (d == CMD_NBA_FALSE) ||
               (d == CMD_FGET_CLR) || (d == CMD_FGET_SET) ||
               (d == CMD_RTL_CLR) || (d == CMD_RTL_SET);
    endfunction

endpackage

// ---- aux_cmd_if.sv ----
/*
 * One-cycle command strobes passed from the command latch to the
 * decoder state logic. Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface aux_cmd_if;
    logic swrst_set;
    logic swrst_clr;
    logic dac_valid;
    logic dac_invalid;
    logic rfd_release;
    logic hdfa_set;
    logic hdfa_clr;
    logic hdfe_set;
    logic hdfe_clr;
    logic nba_false;
    logic fget_set;
    logic fget_clr;
    logic rtl_set;
    logic rtl_clr;

    modport source (
        output swrst_set, swrst_clr, dac_valid, dac_invalid, rfd_release,
        output hdfa_set, hdfa_clr, hdfe_set, hdfe_clr, nba_false,
        output fget_set, fget_clr, rtl_set, rtl_clr
    );
    modport sink (
        input swrst_set, swrst_clr, dac_valid, dac_invalid, rfd_release,
        input hdfa_set, hdfa_clr, hdfe_set, hdfe_clr, nba_false,
        input fget_set, fget_clr, rtl_set, rtl_clr
    );
endinterface

// ---- aux_cmd_latch.sv ----
/*
 * Registers a command register write and turns a defined code into exactly
 * one command strobe, one clock wide, in the cycle after the write.
 * Assumes cmd_write is a one-cycle strobe synchronous to clock.
 */
`timescale 1ns/10ps
module aux_cmd_latch (
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_data,
    aux_cmd_if.source cmds
);

    // Reserved codes match nothing, so they leave every strobe low
    always_ff @(posedge clock or posedge rst) begin // RULE_21
        if (rst) begin
            cmds.swrst_set <= 1'b0;
            cmds.swrst_clr <= 1'b0;
            cmds.dac_valid <= 1'b0;
            cmds.dac_invalid <= 1'b0;
            cmds.rfd_release <= 1'b0;
            cmds.hdfa_set <= 1'b0;
            cmds.hdfa_clr <= 1'b0;
            cmds.hdfe_set <= 1'b0;
            cmds.hdfe_clr <= 1'b0;
            cmds.nba_false <= 1'b0;
            cmds.fget_set <= 1'b0;
            cmds.fget_clr <= 1'b0;
            cmds.rtl_set <= 1'b0;
            cmds.rtl_clr <= 1'b0;
        end else begin
            // RULE_19
            cmds.swrst_set <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_SWRST_SET);
            cmds.swrst_clr <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_SWRST_CLR);
            cmds.dac_valid <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_DAC_VALID);
            cmds.dac_invalid <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_DAC_INVALID);
            cmds.rfd_release <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_RFD_RELEASE);
            cmds.hdfa_set <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_HDFA_SET);
            cmds.hdfa_clr <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_HDFA_CLR);
            cmds.hdfe_set <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_HDFE_SET);
            cmds.hdfe_clr <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_HDFE_CLR);
            cmds.nba_false <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_NBA_FALSE);
            cmds.fget_set <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_FGET_SET);
            cmds.fget_clr <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_FGET_CLR);
            cmds.rtl_set <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_RTL_SET);
            cmds.rtl_clr <= gpib_aux_pkg::code_match(cmd_write, cmd_data,
                gpib_aux_pkg::CMD_RTL_CLR);
        end
    end

    logic [13:0] strobes;
    assign strobes = {cmds.swrst_set, cmds.swrst_clr, cmds.dac_valid, cmds.dac_invalid,
                      cmds.rfd_release, cmds.hdfa_set, cmds.hdfa_clr, cmds.hdfe_set,
                      cmds.hdfe_clr, cmds.nba_false, cmds.fget_set, cmds.fget_clr,
                      cmds.rtl_set, cmds.rtl_clr};

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_strobe_one_cycle: assert property ( // RULE_19
        cmd_write && gpib_aux_pkg::code_defined(cmd_data) && !$past(cmd_write)
        |=> $onehot(strobes) ##1 (strobes == '0))
        else $error("defined command did not give one single-cycle strobe");

    chk_reserved_silent: assert property ( // RULE_21
        cmd_write && !gpib_aux_pkg::code_defined(cmd_data) |=> strobes == '0)
        else $error("reserved command produced a strobe");

    chk_no_write_no_strobe: assert property ( // RULE_19
        !cmd_write |=> strobes == '0)
        else $error("strobe without a command write");

endmodule // aux_cmd_latch

// ---- gpib_aux_command_decoder.sv ----
/*
 * Auxiliary command decoder: software reset, holdoff modes and
 * releases, new-byte-available cancel, forced trigger and return to
 * local. Assumes the interface functions around it give one-cycle event
 * pulses synchronous to clock and obey the level outputs here.
 */
//
// Contract
// RULE_01 - Code 80 sets software reset, forcing interface functions idle like power-on.
// RULE_02 - Hardware reset and chip reset command also set software reset.
// RULE_03 - Code 00 clears software reset, device then joins the bus.
// RULE_04 - Host should configure address, masks and features while software reset set.
// RULE_05 - Codes 01 and 81 release a pending data-accepted holdoff.
// RULE_06 - With pass-through on, 01 marks secondary invalid, 81 marks it valid.
// RULE_07 - Host releases holdoffs from other command bytes with the invalid code.
// RULE_08 - Code 02 releases any ready-for-data holdoff from either holdoff mode.
// RULE_09 - Holdoff-on-all-data mode (83 set, 03 clear) holds off after every byte.
// RULE_10 - In all-data mode host issues release after each received byte.
// RULE_11 - Holdoff-on-end mode (84 set, 04 clear) holds off only after END bytes.
// RULE_12 - Code 05 forces new-byte-available false, so the pending byte is dropped.
// RULE_13 - Code 06 pulses trigger output for at least five clock cycles.
// RULE_14 - Code 86 holds trigger output asserted until code 06.
// RULE_15 - Forced trigger commands never change the trigger-received status bit.
// RULE_16 - Code 07 makes the return-to-local message true for one pulse.
// RULE_17 - Code 87 holds return-to-local true until code 07.
// RULE_18 - Host must not write reserved command codes.
// RULE_19 - Pulsed commands act one clock after the write; static ones set flags.
// RULE_20 - Host leaves at least four clocks between command writes.
// RULE_21 - Reserved codes change no state and assert nothing.
`timescale 1ns/10ps
module gpib_aux_command_decoder #(
    parameter int TRIG_PULSE_LEN = gpib_aux_pkg::TRIG_PULSE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_data,
    input wire logic chip_reset_cmd,
    input wire logic secondary_passthrough_enable,
    input wire logic dac_holdoff_request,
    input wire logic data_byte_received,
    input wire logic byte_is_end,
    input wire logic data_out_written,
    input wire logic byte_sent,
    input wire logic get_command_received,
    input wire logic trigger_status_clear,
    output logic software_reset,
    output logic dac_holdoff,
    output logic secondary_valid,
    output logic secondary_invalid,
    output logic hold_all_data,
    output logic hold_end_only,
    output logic rfd_holdoff,
    output logic new_byte_available,
    output logic trigger_output_pin,
    output logic trigger_received,
    output logic rtl_message
);

    localparam int TRIG_CW = $clog2(TRIG_PULSE_LEN + 1);
    localparam logic [TRIG_CW-1:0] TRIG_LOAD = TRIG_CW'(TRIG_PULSE_LEN);

    aux_cmd_if cmds ();

    aux_cmd_latch latch (
        .clock(clock),
        .rst(rst),
        .cmd_write(cmd_write),
        .cmd_data(cmd_data),
        .cmds(cmds)
    );

    // Set sources win over the clear so a chip reset is never lost
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            software_reset <= 1'b1; // RULE_02
        end else if (cmds.swrst_set || chip_reset_cmd) begin
            software_reset <= 1'b1; // RULE_01 RULE_02
        end else if (cmds.swrst_clr) begin
            software_reset <= 1'b0; // RULE_03
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dac_holdoff <= 1'b0;
        end else if (dac_holdoff_request) begin
            dac_holdoff <= 1'b1;
        end else if (cmds.dac_valid || cmds.dac_invalid) begin
            dac_holdoff <= 1'b0; // RULE_05
        end
    end

    // Verdict on the secondary address only matters in pass-through
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            secondary_valid <= 1'b0;
            secondary_invalid <= 1'b0;
        end else begin
            secondary_valid <= cmds.dac_valid && secondary_passthrough_enable; // RULE_06
            secondary_invalid <= cmds.dac_invalid && secondary_passthrough_enable; // RULE_06
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_all_data <= 1'b0;
            hold_end_only <= 1'b0;
        end else begin
            if (cmds.hdfa_set) begin
                hold_all_data <= 1'b1; // RULE_09
            end else if (cmds.hdfa_clr) begin
                hold_all_data <= 1'b0; // RULE_09
            end
            if (cmds.hdfe_set) begin
                hold_end_only <= 1'b1; // RULE_11
            end else if (cmds.hdfe_clr) begin
                hold_end_only <= 1'b0; // RULE_11
            end
        end
    end

    // A byte landing with the release starts a fresh holdoff
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rfd_holdoff <= 1'b0;
        end else if (data_byte_received && (hold_all_data || (hold_end_only && byte_is_end))) begin
            rfd_holdoff <= 1'b1; // RULE_09 RULE_11
        end else if (cmds.rfd_release) begin
            rfd_holdoff <= 1'b0; // RULE_08
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            new_byte_available <= 1'b0;
        end else if (data_out_written) begin
            new_byte_available <= 1'b1;
        end else if (cmds.nba_false || byte_sent) begin
            new_byte_available <= 1'b0; // RULE_12
        end
    end

    logic trig_hold;
    logic [TRIG_CW-1:0] trig_count;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trig_hold <= 1'b0;
            trig_count <= '0;
        end else if (cmds.fget_set) begin
            trig_hold <= 1'b1; // RULE_14
        end else if (cmds.fget_clr) begin
            trig_hold <= 1'b0; // RULE_14
            trig_count <= TRIG_LOAD; // RULE_13
        end else if (trig_count != '0) begin
            trig_count <= trig_count - 1'b1; // RULE_13
        end
    end

    assign trigger_output_pin = trig_hold || (trig_count != '0);

    // Only the bus GET message sets this and trigger_status_clear clears it; forced triggers bypass it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trigger_received <= 1'b0;
        end else if (get_command_received) begin
            trigger_received <= 1'b1; // RULE_15
        end else if (trigger_status_clear) begin
            trigger_received <= 1'b0;
        end
    end

    logic rtl_hold;
    logic rtl_pulse;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rtl_hold <= 1'b0;
            rtl_pulse <= 1'b0;
        end else begin
            rtl_pulse <= cmds.rtl_clr; // RULE_16
            if (cmds.rtl_set) begin
                rtl_hold <= 1'b1; // RULE_17
            end else if (cmds.rtl_clr) begin
                rtl_hold <= 1'b0; // RULE_17
            end
        end
    end

    assign rtl_message = rtl_hold || rtl_pulse;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_swrst_by_code: assert property ( // RULE_01
        cmd_write && cmd_data == gpib_aux_pkg::CMD_SWRST_SET |=> ##1 software_reset)
        else $error("code 80 did not set software reset");

    chk_swrst_by_chip: assert property ( // RULE_02
        chip_reset_cmd |=> software_reset)
        else $error("chip reset did not set software reset");

    chk_swrst_clear: assert property ( // RULE_03
        cmds.swrst_clr && !chip_reset_cmd |=> !software_reset)
        else $error("code 00 did not clear software reset");

    chk_dac_release: assert property ( // RULE_05
        (cmds.dac_valid || cmds.dac_invalid) && !dac_holdoff_request |=> !dac_holdoff)
        else $error("data-accepted holdoff not released");

    chk_secondary_verdict: assert property ( // RULE_06
        cmd_write && secondary_passthrough_enable && cmd_data == gpib_aux_pkg::CMD_DAC_VALID
        ##1 secondary_passthrough_enable |=> secondary_valid && !secondary_invalid)
        else $error("valid secondary not reported");

    chk_rfd_release: assert property ( // RULE_08
        cmds.rfd_release && !data_byte_received |=> !rfd_holdoff)
        else $error("ready-for-data holdoff not released");

    chk_hold_all: assert property ( // RULE_09
        hold_all_data && data_byte_received |=> rfd_holdoff)
        else $error("no holdoff after data byte in all-data mode");

    chk_hold_end_only: assert property ( // RULE_11
        !hold_all_data && hold_end_only && data_byte_received && !byte_is_end
        && !rfd_holdoff |=> !rfd_holdoff)
        else $error("holdoff on a non-END byte in end mode");

    chk_nba_false: assert property ( // RULE_12
        cmds.nba_false && !data_out_written |=> !new_byte_available)
        else $error("new byte available not forced false");

    chk_trigger_pulse: assert property ( // RULE_13
        cmds.fget_clr |=> trigger_output_pin [*5])
        else $error("trigger pulse shorter than five cycles");

    chk_trigger_hold: assert property ( // RULE_14
        trigger_output_pin && trig_hold && !cmds.fget_clr |=> trigger_output_pin)
        else $error("forced trigger dropped before code 06");

    chk_get_untouched: assert property ( // RULE_15
        !get_command_received && !trigger_status_clear |=> $stable(trigger_received))
        else $error("trigger status changed by a forced trigger");

    chk_rtl_pulse: assert property ( // RULE_16
        cmds.rtl_clr |=> rtl_message ##1 !rtl_message)
        else $error("return to local pulse not one cycle");

    chk_rtl_hold: assert property ( // RULE_17
        cmds.rtl_set |=> rtl_message)
        else $error("return to local not held");

    cov_swrst_release: cover property (software_reset ##1 !software_reset);
    cov_trigger_pulse: cover property (cmds.fget_clr ##1 trigger_output_pin [*5]
        ##1 !trigger_output_pin);
    cov_end_holdoff: cover property (hold_end_only && data_byte_received && byte_is_end
        ##1 rfd_holdoff);
    cov_rtl_held: cover property (cmds.rtl_set ##1 rtl_message [*3]);

endmodule // gpib_aux_command_decoder

// ---- gpib_bus_model.sv ----
/*
 * Behavioural model of the listener/talker functions on the bus side.
 * Produces one-cycle event pulses for the command decoder. It assumes
 * the bench calls its tasks and that clock is the decoder's clock.
 */
`timescale 1ns/10ps
module gpib_bus_model (
    input wire logic clock,
    output logic dac_holdoff_request,
    output logic data_byte_received,
    output logic byte_is_end,
    output logic byte_sent,
    output logic get_command_received
);
    initial begin
        dac_holdoff_request = 1'b0;
        data_byte_received = 1'b0;
        byte_is_end = 1'b1;
        byte_sent = 1'b0;
        get_command_received = 1'b0;
    end

    // Qualifier flips outside the pulse so a decoder reading it late sees junk
    task automatic send_byte(input logic is_end);
        @(posedge clock);
        #1;
        data_byte_received = 1'b1;
        byte_is_end = is_end;
        @(posedge clock);
        #1;
        data_byte_received = 1'b0;
        byte_is_end = ~is_end;
    endtask

    // 0: holdoff request, 1: byte sent, 2: bus trigger seen
    task automatic event_pulse(input int sel);
        @(posedge clock);
        #1;
        dac_holdoff_request = (sel == 0);
        byte_sent = (sel == 1);
        get_command_received = (sel == 2);
        @(posedge clock);
        #1;
        dac_holdoff_request = 1'b0;
        byte_sent = 1'b0;
        get_command_received = 1'b0;
    endtask
endmodule // gpib_bus_model

// ---- gpib_aux_command_decoder_tb_top.sv ----
/*
 * Self-checking bench for the auxiliary command decoder. It plays the
 * host on the command side and drives the bus model on the far side;
 * all inputs change 1 ns after the rising clock edge.
 */
`timescale 1ns/10ps
module gpib_aux_command_decoder_tb_top;
    localparam int TRIG_LEN = 5;
    logic clock, rst, cmd_write, chip_reset_cmd, secondary_passthrough_enable;
    logic [7:0] cmd_data;
    logic data_out_written, trigger_status_clear;
    logic dac_holdoff_request, data_byte_received, byte_is_end, byte_sent, get_command_received;
    logic software_reset, dac_holdoff, secondary_valid, secondary_invalid, hold_all_data;
    logic hold_end_only, rfd_holdoff, new_byte_available, trigger_output_pin;
    logic trigger_received, rtl_message;
    logic [15:0] outs;
    int bad_count = 0;
    int n_checks = 0;

    assign outs = {5'h00, software_reset, dac_holdoff, secondary_valid, secondary_invalid,
        hold_all_data, hold_end_only, rfd_holdoff, new_byte_available, trigger_output_pin,
        trigger_received, rtl_message};

    gpib_aux_command_decoder #(.TRIG_PULSE_LEN(TRIG_LEN)) i_dut (
        .clock(clock), .rst(rst), .cmd_write(cmd_write), .cmd_data(cmd_data),
        .chip_reset_cmd(chip_reset_cmd),
        .secondary_passthrough_enable(secondary_passthrough_enable),
        .dac_holdoff_request(dac_holdoff_request), .data_byte_received(data_byte_received),
        .byte_is_end(byte_is_end), .data_out_written(data_out_written),
        .byte_sent(byte_sent), .get_command_received(get_command_received),
        .trigger_status_clear(trigger_status_clear), .software_reset(software_reset),
        .dac_holdoff(dac_holdoff), .secondary_valid(secondary_valid),
        .secondary_invalid(secondary_invalid), .hold_all_data(hold_all_data),
        .hold_end_only(hold_end_only), .rfd_holdoff(rfd_holdoff),
        .new_byte_available(new_byte_available), .trigger_output_pin(trigger_output_pin),
        .trigger_received(trigger_received), .rtl_message(rtl_message)
    );

    gpib_bus_model i_bus (
        .clock(clock), .dac_holdoff_request(dac_holdoff_request),
        .data_byte_received(data_byte_received), .byte_is_end(byte_is_end),
        .byte_sent(byte_sent), .get_command_received(get_command_received)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Idle gap first keeps writes five cycles apart; returns in the answer cycle
    task automatic write_cmd(input logic [7:0] code);
        tick(3);
        cmd_write = 1'b1;
        cmd_data = code;
        tick(1);
        cmd_write = 1'b0;
        cmd_data = ~code;
        tick(1);
    endtask

    // 0: chip reset, 1: data-out written, 2: trigger status clear
    task automatic host_pulse(input int sel);
        tick(1);
        chip_reset_cmd = (sel == 0);
        data_out_written = (sel == 1);
        trigger_status_clear = (sel == 2);
        tick(1);
        {chip_reset_cmd, data_out_written, trigger_status_clear} = 3'h0;
        tick(1);
    endtask

    task automatic t_swrst();
        check(outs, 16'h0400);
        secondary_passthrough_enable = 1'b1;
        write_cmd(8'h00);
        check(software_reset, 16'h0000);
        write_cmd(8'h80);
        check(software_reset, 16'h0001);
        write_cmd(8'h00);
        host_pulse(0);
        check(software_reset, 16'h0001);
        write_cmd(8'h00);
        $display("test swrst done");
    endtask

    task automatic t_dac();
        i_bus.event_pulse(0);
        tick(1);
        check(dac_holdoff, 16'h0001);
        write_cmd(8'h81);
        check({dac_holdoff, secondary_valid, secondary_invalid}, 16'h0002);
        tick(1);
        check(secondary_valid, 16'h0000);
        i_bus.event_pulse(0);
        write_cmd(8'h01);
        check({dac_holdoff, secondary_valid, secondary_invalid}, 16'h0001);
        secondary_passthrough_enable = 1'b0;
        i_bus.event_pulse(0);
        write_cmd(8'h01);
        check({dac_holdoff, secondary_invalid}, 16'h0000);
        $display("test dac done");
    endtask

    task automatic t_hold();
        write_cmd(8'h83);
        check(hold_all_data, 16'h0001);
        i_bus.send_byte(1'b0);
        tick(1);
        check(rfd_holdoff, 16'h0001);
        write_cmd(8'h02);
        check(rfd_holdoff, 16'h0000);
        write_cmd(8'h03);
        write_cmd(8'h84);
        check({hold_all_data, hold_end_only}, 16'h0001);
        i_bus.send_byte(1'b0);
        tick(1);
        check(rfd_holdoff, 16'h0000);
        i_bus.send_byte(1'b1);
        tick(1);
        check(rfd_holdoff, 16'h0001);
        write_cmd(8'h02);
        check(rfd_holdoff, 16'h0000);
        write_cmd(8'h04);
        i_bus.send_byte(1'b1);
        tick(1);
        check({hold_end_only, rfd_holdoff}, 16'h0000);
        $display("test holdoff done");
    endtask

    task automatic t_nba();
        host_pulse(1);
        check(new_byte_available, 16'h0001);
        write_cmd(8'h05);
        check(new_byte_available, 16'h0000);
        host_pulse(1);
        i_bus.event_pulse(1);
        tick(1);
        check(new_byte_available, 16'h0000);
        $display("test nba done");
    endtask

    task automatic trig_tail();
        for (int i = 0; i < TRIG_LEN; i++) begin
            check(trigger_output_pin, 16'h0001);
            tick(1);
        end
        check(trigger_output_pin, 16'h0000);
    endtask

    task automatic t_trig();
        i_bus.event_pulse(2);
        tick(1);
        write_cmd(8'h06);
        trig_tail();
        check(trigger_received, 16'h0001);
        write_cmd(8'h86);
        tick(12);
        check(trigger_output_pin, 16'h0001);
        write_cmd(8'h06);
        trig_tail();
        host_pulse(2);
        write_cmd(8'h86);
        check({trigger_output_pin, trigger_received}, 16'h0002);
        write_cmd(8'h06);
        tick(TRIG_LEN);
        $display("test trigger done");
    endtask

    task automatic t_rtl();
        write_cmd(8'h07);
        check(rtl_message, 16'h0001);
        tick(1);
        check(rtl_message, 16'h0000);
        write_cmd(8'h87);
        tick(9);
        check(rtl_message, 16'h0001);
        write_cmd(8'h07);
        tick(1);
        check(rtl_message, 16'h0000);
        $display("test rtl done");
    endtask

    // Mid-run reset must drop every mode and the forced trigger at once
    task automatic t_rst_mid();
        write_cmd(8'h83);
        write_cmd(8'h86);
        check(outs, 16'h0044);
        rst = 1'b1;
        tick(1);
        check(outs, 16'h0400);
        rst = 1'b0;
        tick(1);
        check(outs, 16'h0400);
        write_cmd(8'h00);
        check(software_reset, 16'h0000);
        $display("test reset done");
    endtask

    // Deliberate reserved writes with state held, to prove they are inert
    task automatic t_reserved();
        logic [7:0] codes [4] = '{8'h08, 8'h1c, 8'h7f, 8'hff};
        logic [15:0] exp;
        write_cmd(8'h83);
        write_cmd(8'h87);
        exp = 16'h0041;
        foreach (codes[i]) begin
            write_cmd(codes[i]);
            check(outs, exp);
            tick(2);
            check(outs, exp);
        end
        $display("test reserved done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        {cmd_write, chip_reset_cmd, data_out_written, trigger_status_clear} = 4'h0;
        secondary_passthrough_enable = 1'b0;
        cmd_data = 8'h00;
        tick(8);
        rst = 1'b0;
        tick(1);
        t_swrst();
        t_dac();
        t_hold();
        t_nba();
        t_trig();
        t_rtl();
        t_rst_mid();
        t_reserved();
        print_verdict();
    end
endmodule // gpib_aux_command_decoder_tb_top
